/* File: shared/adc_acc_pkg.sv */
// Notes on behaviour
// - threshold count limit: 8-bit read/write, resets to one, sets hits needed for flag.
// - threshold flag sets the moment the count equals the programmed limit.
// - 8-bit read-only count, reset zero, increments when magnitude reaches threshold with comparator set to CMP_DEC or CMP_CLEAR.
// - below-threshold result decrements or clears the count, per comparator setting.
// - magnitude compared each result; two-bit comparator field; flag when above threshold unless the field is CMP_OFF.
// - read-only 32-bit accumulator of current results, reset to zero.
// - accumulator clears when disabled or the current channel is reconfigured.
// - two-bit field enables accumulator and picks add or subtract.
// - one mode bit selects precision or low-power reference.
// - two-bit mode field picks normal, low power or low power plus, independent of core.
// - normal mode: 512 kHz modulator clock, all channels on, default 1 kHz rate.
// - low power: current channel only, 131 kHz oscillator, gain fixed at 128; single conversions run as in normal mode instead.
// - low power plus: as low power but gain fixed at 512; single conversions run as in normal mode instead.
// - counter, comparator and accumulator work in every power mode.
// - single-conversion command converts once then returns to full power-down.
// - threshold uses 16 bits for unipolar results, low 15 bits for twos complement.
`default_nettype none
package adc_acc_pkg;

  // register byte addresses
  localparam logic [31:0] MAGNITUDE_THRESHOLD_ADDR     = 32'hFFFF0550;
  localparam logic [31:0] THRESHOLD_COUNT_LIMIT_ADDR   = 32'hFFFF0554;
  localparam logic [31:0] THRESHOLD_COUNT_VALUE_ADDR   = 32'hFFFF0558;
  localparam logic [31:0] CURRENT_ACCUMULATOR_ADDR     = 32'hFFFF055C;
  localparam logic [31:0] LOW_POWER_REF_SCALE_ADDR     = 32'hFFFF057C;
  localparam logic [31:0] CONVERTER_CONFIG_ADDR        = 32'hFFFF0580;
  localparam logic [31:0] CONVERTER_MODE_ADDR          = 32'hFFFF0584;
  localparam logic [31:0] CURRENT_CHANNEL_CONTROL_ADDR = 32'hFFFF0588;
  localparam logic [31:0] CONVERTER_STATUS_ADDR        = 32'hFFFF058C;
  localparam logic [31:0] FILTER_CONFIG_ADDR           = 32'hFFFF0590;

  // values after reset
  localparam logic [15:0] MAGNITUDE_THRESHOLD_RST      = 16'h0000;
  localparam logic [7:0]  THRESHOLD_COUNT_LIMIT_RST    = 8'h01;
  localparam logic [7:0]  THRESHOLD_COUNT_VALUE_RST    = 8'h00;
  localparam logic [31:0] CURRENT_ACCUMULATOR_RST      = 32'h00000000;
  localparam logic [15:0] LOW_POWER_REF_SCALE_RST      = 16'h8000; // part trimmed; unity here
  localparam logic [7:0]  CONVERTER_CONFIG_RST         = 8'h00;
  localparam logic [7:0]  CONVERTER_MODE_RST           = 8'h00;
  localparam logic [15:0] CURRENT_CHANNEL_CONTROL_RST  = 16'h0000;
  localparam logic [15:0] FILTER_CONFIG_RST            = 16'h0007; // 1 kHz update rate

  // field positions
  localparam int CFG_CMP_LSB     = 3;
  localparam int CFG_ACC_EN_BIT  = 5;
  localparam int CFG_ACC_SUB_BIT = 6;
  localparam int MDE_OP_LSB      = 0;
  localparam int MDE_PWR_LSB     = 3;
  localparam int MDE_REF_BIT     = 5;
  localparam int STA_READY_BIT   = 0;
  localparam int STA_CMP_BIT     = 3;
  localparam int STA_COUNT_BIT   = 4;

  // clock and gain figures per power mode
  localparam int MOD_CLK_NORMAL_KHZ = 512;
  localparam int LP_OSC_KHZ         = 131;
  localparam int GAIN_LOW_POWER     = 128;
  localparam int GAIN_LOW_POWER_PLUS = 512;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    CMP_OFF   = 2'b00,
    CMP_FLAG  = 2'b01,
    CMP_DEC   = 2'b10,
    CMP_CLEAR = 2'b11
  } cmp_mode_t;

  typedef enum logic [1:0] {
    PWR_NORMAL  = 2'b00,
    PWR_LOW     = 2'b01,
    PWR_LOWPLUS = 2'b10,
    PWR_RSVD    = 2'b11
  } power_mode_t;

  typedef enum logic [2:0] {
    OP_POWER_DOWN = 3'b000,
    OP_CONTINUOUS = 3'b001,
    OP_SINGLE     = 3'b010,
    OP_IDLE       = 3'b011,
    OP_CAL_A      = 3'b100,
    OP_CAL_B      = 3'b101,
    OP_CAL_C      = 3'b110,
    OP_CAL_D      = 3'b111
  } op_mode_t;

endpackage
`default_nettype wire

/* File: design/threshold_compare.sv */
`timescale 1ns/10ps
`default_nettype none
module threshold_compare (
  // result and its format
  input  wire logic [15:0] result,
  input  wire logic        unipolar,
  // programmed threshold
  input  wire logic [15:0] threshold,
  // comparisons against the magnitude
  output logic             at_or_above,
  output logic             above
);

  logic [15:0] magnitude;
  logic [15:0] limit;

  // sign-free magnitude; -32768 maps to 0x8000, still within 16 bits
  always_comb begin
    if (unipolar) begin
      magnitude = result;
      limit     = threshold;
    end else begin
      magnitude = result[15] ? (~result + 16'h0001) : result;
      limit     = {1'b0, threshold[14:0]};
    end
    at_or_above = (magnitude >= limit);
    above       = (magnitude > limit);
  end

endmodule
`default_nettype wire

/* File: design/current_adc_threshold_accumulator.sv */
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module current_adc_threshold_accumulator (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // axi4-lite write address
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  // axi4-lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // axi4-lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read address
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  // axi4-lite read data
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // results from the decimation filter
  input  wire logic [15:0] result_data,
  input  wire logic        result_unipolar,
  input  wire logic        result_valid,
  // converter control toward the analog side
  output logic             modulator_on,
  output logic             modulator_clk_lp,
  output logic             current_channel_run,
  output logic             vt_channel_run,
  output logic             gain_fixed_en,
  output logic             gain_fixed_512,
  output logic             lp_reference_sel,
  output logic [15:0]      current_channel_ctrl,
  output logic [15:0]      filter_config,
  // event flags
  output logic             compare_flag,
  output logic             count_flag
);
  import adc_acc_pkg::*;

  typedef struct packed {
    // bus side
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        aw_have;
    logic [31:0] aw_addr;
    logic        w_have;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    // registers
    logic [15:0] threshold;
    logic [7:0]  count_limit;
    logic [7:0]  count_value;
    logic [31:0] accumulator;
    logic [15:0] ref_scale;
    logic [7:0]  config_reg;
    logic [1:0]  power;
    logic        ref_lp;
    op_mode_t    op;
    logic [15:0] chan_ctrl;
    logic [15:0] filter_cfg;
    logic        ready_flag;
    logic        cmp_flag;
    logic        cnt_flag;
    // registered control outputs
    logic        mod_on;
    logic        mod_clk_lp;
    logic        cur_run;
    logic        vt_run;
    logic        gain_en;
    logic        gain_512;
  } state_t;

  state_t      s_q;
  state_t      s_d;
  logic        at_or_above;
  logic        above;
  logic [31:0] wr_val;
  logic [31:0] rd_val;
  logic        rd_err;
  logic        reconfig;
  logic        converting;
  logic [7:0]  next_count;
  logic [31:0] result_ext;
  logic [2:0]  op_bits;

  threshold_compare u_compare (
    .result      (result_data),
    .unipolar    (result_unipolar),
    .threshold   (s_q.threshold),
    .at_or_above (at_or_above),
    .above       (above)
  );

  // byte-lane merge so partial writes keep untouched lanes
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0]  strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_val[8*i +: 8];
      end
    end
    return res;
  endfunction

  // read mux; unmapped addresses answer slverr with zero data
  always_comb begin
    rd_val = 32'h00000000;
    rd_err = 1'b0;
    case (araddr)
      MAGNITUDE_THRESHOLD_ADDR:     rd_val = {16'h0000, s_q.threshold};
      THRESHOLD_COUNT_LIMIT_ADDR:   rd_val = {24'h000000, s_q.count_limit};
      THRESHOLD_COUNT_VALUE_ADDR:   rd_val = {24'h000000, s_q.count_value};
      CURRENT_ACCUMULATOR_ADDR:     rd_val = s_q.accumulator;
      LOW_POWER_REF_SCALE_ADDR:     rd_val = {16'h0000, s_q.ref_scale};
      CONVERTER_CONFIG_ADDR:        rd_val = {24'h000000, s_q.config_reg};
      CONVERTER_MODE_ADDR:          rd_val = {26'h0000000, s_q.ref_lp, s_q.power, s_q.op};
      CURRENT_CHANNEL_CONTROL_ADDR: rd_val = {16'h0000, s_q.chan_ctrl};
      FILTER_CONFIG_ADDR:           rd_val = {16'h0000, s_q.filter_cfg};
      CONVERTER_STATUS_ADDR: begin
        rd_val[STA_READY_BIT] = s_q.ready_flag;
        rd_val[STA_CMP_BIT]   = s_q.cmp_flag;
        rd_val[STA_COUNT_BIT] = s_q.cnt_flag;
      end
      default:                      rd_err = 1'b1;
    endcase
  end

  // next state of the whole block
  always_comb begin
    s_d        = s_q;
    reconfig   = 1'b0;
    next_count = s_q.count_value;
    op_bits    = 3'h0;
    wr_val     = merge_bytes(32'h00000000, s_q.w_data, s_q.w_strb);
    result_ext = result_unipolar ? {16'h0000, result_data} : {{16{result_data[15]}}, result_data};

    // capture address and data independently, either may come first
    if (awvalid && s_q.awready) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = awaddr;
    end
    if (wvalid && s_q.wready) begin
      s_d.w_have = 1'b1;
      s_d.w_data = wdata;
      s_d.w_strb = wstrb;
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end

    // perform the write once both halves are held
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = RESP_OKAY;
      case (s_q.aw_addr)
        MAGNITUDE_THRESHOLD_ADDR: begin
          s_d.threshold = 16'(merge_bytes({16'h0000, s_q.threshold}, s_q.w_data, s_q.w_strb));
        end
        THRESHOLD_COUNT_LIMIT_ADDR: begin
          s_d.count_limit = 8'(merge_bytes({24'h000000, s_q.count_limit}, s_q.w_data, s_q.w_strb));
        end
        LOW_POWER_REF_SCALE_ADDR: begin
          s_d.ref_scale = 16'(merge_bytes({16'h0000, s_q.ref_scale}, s_q.w_data, s_q.w_strb));
        end
        CONVERTER_CONFIG_ADDR: begin
          s_d.config_reg = 8'(merge_bytes({24'h000000, s_q.config_reg}, s_q.w_data, s_q.w_strb));
        end
        CONVERTER_MODE_ADDR: begin
          if (s_q.w_strb[0]) begin
            op_bits    = s_q.w_data[MDE_OP_LSB +: 3];
            s_d.op     = op_mode_t'(op_bits);
            s_d.power  = s_q.w_data[MDE_PWR_LSB +: 2];
            s_d.ref_lp = s_q.w_data[MDE_REF_BIT];
            reconfig   = 1'b1;
          end
        end
        CURRENT_CHANNEL_CONTROL_ADDR: begin
          s_d.chan_ctrl = 16'(merge_bytes({16'h0000, s_q.chan_ctrl}, s_q.w_data, s_q.w_strb));
          reconfig      = 1'b1;
        end
        FILTER_CONFIG_ADDR: begin
          s_d.filter_cfg = 16'(merge_bytes({16'h0000, s_q.filter_cfg}, s_q.w_data, s_q.w_strb));
        end
        CONVERTER_STATUS_ADDR: begin
          // write one to clear; a same-cycle event sets it again below
          if (wr_val[STA_READY_BIT]) s_d.ready_flag = 1'b0;
          if (wr_val[STA_CMP_BIT])   s_d.cmp_flag   = 1'b0;
          if (wr_val[STA_COUNT_BIT]) s_d.cnt_flag   = 1'b0;
        end
        THRESHOLD_COUNT_VALUE_ADDR, CURRENT_ACCUMULATOR_ADDR: begin
          s_d.bresp = RESP_OKAY; // read-only, write dropped
        end
        default: s_d.bresp = RESP_SLVERR;
      endcase
    end

    // read path: one outstanding read, answered the cycle after the address
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    if (arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = rd_val;
      s_d.rresp  = rd_err ? RESP_SLVERR : RESP_OKAY;
    end

    // reconfiguring the channel restarts counter and accumulator
    if (reconfig) begin
      s_d.accumulator = CURRENT_ACCUMULATOR_RST;
      s_d.count_value = THRESHOLD_COUNT_VALUE_RST;
    end

    // results are only taken while a conversion mode is active
    converting = (s_q.op == OP_CONTINUOUS) || (s_q.op == OP_SINGLE);
    // power mode does not gate the post-processing at all
    if (result_valid && converting && !reconfig) begin
      s_d.ready_flag = 1'b1;
      if ((cmp_mode_t'(s_q.config_reg[CFG_CMP_LSB +: 2]) != CMP_OFF) && above) begin
        s_d.cmp_flag = 1'b1;
      end
      unique case (cmp_mode_t'(s_q.config_reg[CFG_CMP_LSB +: 2]))
        CMP_OFF, CMP_FLAG: next_count = s_q.count_value;
        CMP_DEC: begin
          if (at_or_above) begin
            next_count = (s_q.count_value == 8'hFF) ? 8'hFF : s_q.count_value + 8'h01;
          end else if (s_q.count_value != 8'h00) begin
            next_count = s_q.count_value - 8'h01;
          end else begin
            next_count = 8'h00;
          end
        end
        CMP_CLEAR: begin
          if (at_or_above) begin
            next_count = (s_q.count_value == 8'hFF) ? 8'hFF : s_q.count_value + 8'h01;
          end else begin
            next_count = 8'h00;
          end
        end
      endcase
      s_d.count_value = next_count;
      if ((next_count != s_q.count_value) && (next_count == s_q.count_limit)) begin
        s_d.cnt_flag = 1'b1;
      end
      if (s_q.config_reg[CFG_ACC_EN_BIT]) begin
        // add or subtract each new result
        s_d.accumulator = s_q.config_reg[CFG_ACC_SUB_BIT] ? s_q.accumulator - result_ext
                                                           : s_q.accumulator + result_ext;
      end
      if (s_q.op == OP_SINGLE) begin
        s_d.op = OP_POWER_DOWN;
      end
    end

    // disabled accumulator is held at zero
    if (!s_d.config_reg[CFG_ACC_EN_BIT]) begin
      s_d.accumulator = CURRENT_ACCUMULATOR_RST;
    end

    // analog control; single conversions always run at full power
    s_d.mod_on = (s_d.op != OP_POWER_DOWN);
    unique case (power_mode_t'(s_d.power))
      PWR_NORMAL: begin
        s_d.mod_clk_lp = 1'b0;
        s_d.gain_en    = 1'b0;
        s_d.gain_512   = 1'b0;
      end
      PWR_LOW, PWR_RSVD: begin
        s_d.mod_clk_lp = 1'b1;
        s_d.gain_en    = 1'b1;
        s_d.gain_512   = 1'b0;
      end
      PWR_LOWPLUS: begin
        s_d.mod_clk_lp = 1'b1;
        s_d.gain_en    = 1'b1;
        s_d.gain_512   = 1'b1;
      end
    endcase
    if (s_d.op == OP_SINGLE) begin
      s_d.mod_clk_lp = 1'b0;
      s_d.gain_en    = 1'b0;
      s_d.gain_512   = 1'b0;
    end
    s_d.cur_run = (s_d.op == OP_CONTINUOUS) || (s_d.op == OP_SINGLE);
    // voltage and temperature channels only run on the full-rate clock
    s_d.vt_run  = s_d.cur_run && !s_d.mod_clk_lp;

    // readies follow the holding state so outputs stay registered
    s_d.awready = !s_d.aw_have && !s_d.bvalid;
    s_d.wready  = !s_d.w_have && !s_d.bvalid;
    s_d.arready = !s_d.rvalid;
  end

  // single state register
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q             <= '0;
      s_q.bresp       <= RESP_OKAY;
      s_q.rresp       <= RESP_OKAY;
      s_q.threshold   <= MAGNITUDE_THRESHOLD_RST;
      s_q.count_limit <= THRESHOLD_COUNT_LIMIT_RST;
      s_q.count_value <= THRESHOLD_COUNT_VALUE_RST;
      s_q.accumulator <= CURRENT_ACCUMULATOR_RST;
      s_q.ref_scale   <= LOW_POWER_REF_SCALE_RST;
      s_q.config_reg  <= CONVERTER_CONFIG_RST;
      s_q.power       <= CONVERTER_MODE_RST[MDE_PWR_LSB +: 2];
      s_q.ref_lp      <= CONVERTER_MODE_RST[MDE_REF_BIT];
      s_q.op          <= OP_POWER_DOWN;
      s_q.chan_ctrl   <= CURRENT_CHANNEL_CONTROL_RST;
      s_q.filter_cfg  <= FILTER_CONFIG_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // bus outputs
  assign awready = s_q.awready;
  assign wready  = s_q.wready;
  assign bvalid  = s_q.bvalid;
  assign bresp   = s_q.bresp;
  assign arready = s_q.arready;
  assign rvalid  = s_q.rvalid;
  assign rdata   = s_q.rdata;
  assign rresp   = s_q.rresp;

  // converter control and flags
  assign modulator_on         = s_q.mod_on;
  assign modulator_clk_lp     = s_q.mod_clk_lp;
  assign current_channel_run  = s_q.cur_run;
  assign vt_channel_run       = s_q.vt_run;
  assign gain_fixed_en        = s_q.gain_en;
  assign gain_fixed_512       = s_q.gain_512;
  assign lp_reference_sel     = s_q.ref_lp;
  assign current_channel_ctrl = s_q.chan_ctrl;
  assign filter_config        = s_q.filter_cfg;
  assign compare_flag         = s_q.cmp_flag;
  assign count_flag           = s_q.cnt_flag;

endmodule
`default_nettype wire

/* File: test/adc_acc_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module adc_acc_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // register bus
  input wire logic        awready,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  // results and converter control
  input wire logic        result_valid,
  input wire logic        modulator_on,
  input wire logic        modulator_clk_lp,
  input wire logic        current_channel_run,
  input wire logic        vt_channel_run,
  input wire logic        gain_fixed_en,
  input wire logic        gain_fixed_512,
  input wire logic        compare_flag,
  input wire logic        count_flag
);
  import adc_acc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // answers stand until taken; readies come back after
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped early");
  a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read not answered next cycle");
  a_write_reopen: assert property (bvalid && bready |=> awready && wready && !bvalid)
    else $error("write side not reopened");
  // flags rise only from a taken result, fall only when a write lands
  a_cmp_cause: assert property ($rose(compare_flag) |-> $past(result_valid && current_channel_run))
    else $error("compare flag rose without a result");
  a_cnt_cause: assert property ($rose(count_flag) |-> $past(result_valid && current_channel_run))
    else $error("count flag rose without a result");
  a_cmp_sticky: assert property ($fell(compare_flag) |-> $rose(bvalid))
    else $error("compare flag lost without a clear");
  a_cnt_sticky: assert property ($fell(count_flag) |-> $rose(bvalid))
    else $error("count flag lost without a clear");
  // power mode pin relations
  a_lp_clock: assert property (gain_fixed_en |-> modulator_clk_lp)
    else $error("fixed gain on normal clock");
  a_lp_gain: assert property (gain_fixed_512 |-> gain_fixed_en)
    else $error("gain 512 without fixed gain");
  a_vt_normal: assert property (vt_channel_run |-> current_channel_run && !modulator_clk_lp)
    else $error("other channels run outside normal mode");
  a_run_on: assert property (current_channel_run |-> modulator_on)
    else $error("channel runs with modulator off");
  c_cmp_set: cover property ($rose(compare_flag));
  c_cnt_set: cover property ($rose(count_flag));
  c_slverr: cover property (rvalid && rresp == RESP_SLVERR);
endmodule
bind current_adc_threshold_accumulator adc_acc_chk chk (.clk, .rst, .awready, .wready, .bresp, .bvalid,
  .bready, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .result_valid, .modulator_on,
  .modulator_clk_lp, .current_channel_run, .vt_channel_run, .gain_fixed_en, .gain_fixed_512,
  .compare_flag, .count_flag);
`default_nettype wire

/* File: test/filter_model.sv */
`timescale 1ns/10ps
`default_nettype none
module filter_model (
  // clock
  input wire logic         clk,
  // result stream toward the block
  output logic [15:0]      result_data,
  output logic             result_unipolar,
  output logic             result_valid
);
  initial begin
    result_data = 16'h0000;
    result_unipolar = 1'b0;
    result_valid = 1'b0;
  end
  // one result per call; data inverted after so a stale word never looks live
  task automatic send(input logic [15:0] d, input logic u);
    @(posedge clk);
    result_data <= d;
    result_unipolar <= u;
    result_valid <= 1'b1;
    @(posedge clk);
    result_valid <= 1'b0;
    result_data <= ~d;
  endtask
endmodule
`default_nettype wire

/* File: test/current_adc_threshold_accumulator_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module current_adc_threshold_accumulator_tb;
  import adc_acc_pkg::*;
  logic        clk, rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rdata, rv, acc;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  logic [15:0] result_data, current_channel_ctrl, filter_config, th, d, m, t;
  logic        result_unipolar, result_valid, modulator_on, modulator_clk_lp, current_channel_run, u;
  logic        vt_channel_run, gain_fixed_en, gain_fixed_512, lp_reference_sel, compare_flag, count_flag;
  logic        ef_c, ef_n;
  logic [7:0]  lim, cnt, old;
  int          n_errors = 0;
  int          n_checks = 0;

  current_adc_threshold_accumulator uut (.clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .result_data, .result_unipolar, .result_valid, .modulator_on, .modulator_clk_lp, .current_channel_run,
    .vt_channel_run, .gain_fixed_en, .gain_fixed_512, .lp_reference_sel, .current_channel_ctrl,
    .filter_config, .compare_flag, .count_flag);
  filter_model fm (.clk, .result_data, .result_unipolar, .result_valid);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // both halves offered together, each dropped when taken; bready trails bvalid a cycle
  task automatic wr(input logic [31:0] a, input logic [31:0] dat);
    int k;
    k = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= dat;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && !bready) bready <= 1'b1;
      rs = bresp;
      if (++k > 60) begin
        n_errors++;
        final_report();
      end
    end while (!(bvalid && bready));
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a);
    int k;
    k = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    // rready trails rvalid so the read hold is exercised
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && !rready) rready <= 1'b1;
      rv = rdata;
      rs = rresp;
      if (++k > 60) begin
        n_errors++;
        final_report();
      end
    end while (!(rvalid && rready));
    rready <= 1'b0;
  endtask

  function automatic logic [15:0] mag(input logic [15:0] x, input logic uni);
    return (uni || !x[15]) ? x : -x;
  endfunction

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    final_report();
  end

  initial begin
    {awaddr, wdata, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hF;
    rst = 1'b1;
    void'($urandom(32'h4D31));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // reset values, read-only writes ignored, unmapped place refused
    rd(THRESHOLD_COUNT_LIMIT_ADDR); chk(rv, 32'h01, "limit reset");
    wr(THRESHOLD_COUNT_VALUE_ADDR, 32'h77); rd(THRESHOLD_COUNT_VALUE_ADDR); chk(rv, 32'h0, "count ro");
    wr(CURRENT_ACCUMULATOR_ADDR, 32'h55); rd(CURRENT_ACCUMULATOR_ADDR); chk(rv, 32'h0, "acc ro");
    wr(THRESHOLD_COUNT_LIMIT_ADDR, 32'h1A5); rd(THRESHOLD_COUNT_LIMIT_ADDR); chk(rv, 32'hA5, "limit rw");
    rd(32'hFFFF0560); chk(rv, 32'h0, "unmapped data");
    chk(32'(rs), 32'(RESP_SLVERR), "unmapped resp");
    chk(32'(filter_config), 32'(FILTER_CONFIG_RST), "filter reset");
    rd(LOW_POWER_REF_SCALE_ADDR); chk(rv, 32'(LOW_POWER_REF_SCALE_RST), "scale");
    wr(CURRENT_CHANNEL_CONTROL_ADDR, 32'h8007); wr(CONVERTER_MODE_ADDR, 32'h09);
    wr(CONVERTER_MODE_ADDR, 32'h03); chk(32'(current_channel_ctrl), 32'h8007, "control kept");
    $display("register test done");
    // comparator in each configuration; first results hit equality (not a unipolar one under CMP_CLEAR) then zero
    for (int c = 0; c < 4; c++) begin
      th = 16'($urandom_range(16'h0FFF, 16'h0100)) | (c == 3 ? 16'h8000 : 16'h0000);
      lim = 8'($urandom_range(6, 2));
      wr(CONVERTER_CONFIG_ADDR, c << CFG_CMP_LSB);
      wr(MAGNITUDE_THRESHOLD_ADDR, {16'h0, th});
      wr(THRESHOLD_COUNT_LIMIT_ADDR, {24'h0, lim});
      wr(CONVERTER_MODE_ADDR, 32'h01);
      wr(CONVERTER_STATUS_ADDR, 32'h18);
      {cnt, ef_c, ef_n} = '0;
      for (int i = 0; i < 14; i++) begin
        u = 1'($urandom);
        d = (i == 0) ? th & 16'h7FFF : (i == 1) ? 16'h0000 : 16'($urandom_range(16'h1FFF, 0));
        if (!u && $urandom % 2) d = -d;
        fm.send(d, u);
        m = mag(d, u);
        t = u ? th : {1'b0, th[14:0]};
        if (c != 0 && m > t) ef_c = 1'b1;
        old = cnt;
        if (c >= 2) cnt = (m >= t) ? ((cnt == 8'hFF) ? cnt : cnt + 8'h01) : ((c == 3 || cnt == 0) ? 8'h00 : cnt - 8'h01);
        if (cnt != old && cnt == lim) ef_n = 1'b1;
        rd(THRESHOLD_COUNT_VALUE_ADDR); chk(rv, {24'h0, cnt}, "count");
      end
      chk(32'(compare_flag), 32'(ef_c), "compare flag");
      chk(32'(count_flag), 32'(ef_n), "count flag");
      $display("comparator test %0d done", c);
    end
    // accumulate add in normal mode, subtract in low power
    for (int s = 0; s < 2; s++) begin
      wr(CONVERTER_CONFIG_ADDR, 32'h20 | (s << CFG_ACC_SUB_BIT));
      wr(CONVERTER_MODE_ADDR, s ? 32'h09 : 32'h01);
      acc = 32'h0;
      for (int i = 0; i < 6; i++) begin
        d = 16'($urandom);
        fm.send(d, 1'b0);
        acc = s ? acc - 32'(signed'(d)) : acc + 32'(signed'(d));
      end
      rd(CONVERTER_STATUS_ADDR); chk(32'(rv[STA_READY_BIT]), 32'h1, "ready");
      rd(CURRENT_ACCUMULATOR_ADDR); chk(rv, acc, "accumulator");
    end
    wr(CONVERTER_MODE_ADDR, 32'h01); rd(CURRENT_ACCUMULATOR_ADDR); chk(rv, 32'h0, "acc mode clear");
    fm.send(16'h1234, 1'b0);
    rd(CURRENT_ACCUMULATOR_ADDR); chk(rv, 32'hFFFFEDCC, "acc sub one");
    wr(CONVERTER_CONFIG_ADDR, 32'h0); rd(CURRENT_ACCUMULATOR_ADDR); chk(rv, 32'h0, "acc off clear");
    $display("accumulator test done");
    // power mode and reference pins
    for (int p = 0; p < 4; p++) begin
      for (int r = 0; r < 2; r++) begin
        wr(CONVERTER_MODE_ADDR, (r << MDE_REF_BIT) | (p << MDE_PWR_LSB) | 1);
        @(posedge clk);
        chk(32'({modulator_on, modulator_clk_lp, gain_fixed_en, gain_fixed_512, lp_reference_sel, vt_channel_run}),
          32'({1'b1, p != 0, p != 0, p == 2, r[0], p == 0}), "mode pins");
      end
    end
    wr(CONVERTER_MODE_ADDR, 32'h0A); // single overrides low power
    chk(32'({current_channel_run, modulator_clk_lp, gain_fixed_en}), 32'h4, "single start");
    fm.send(16'h0010, 1'b1);
    @(posedge clk);
    chk(32'(modulator_on), 32'h0, "single done");
    $display("mode test done");
    final_report();
  end
endmodule
`default_nettype wire
